// ### dv/afp_field_model.sv
// behavioural power switch and field winding seen by the drive output
`timescale 1ns/10ps
module afp_field_model (
    input wire logic drive,
    input wire logic shorted,
    output logic field_hi
);
    // field node sits at battery while the switch is off; a shorted
    // winding holds it high even with the switch on
    assign field_hi = shorted | ~drive;
endmodule

// ### dv/afp_field_pwm_test.sv
// self-checking bench for the alternator field pwm controller
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module afp_field_pwm_test;
    logic clock, rst_b, ign, sta, ov, shorted, drive, lamp, irq;
    logic field_hi, seen;
    logic [7:0] sense_code;
    logic [31:0] rdata, d;
    afp_pkg::afp_bus_t bus;
    afp_pkg::afp_flags_t flags;
    int num_errors, n_compared, hi;
    time t_a, t_b;
    localparam logic [31:0] PER = 32'h0000_00C8;
    logic [7:0] codes [4] = '{8'h40, 8'h80, 8'hA0, 8'hFF};
    int exp_hi [4] = '{190, 115, 40, 24};

    assign flags = {ign, sta, ov, field_hi};

    // short counts keep the run brief; the reset period and the upper
    // pulse bounds keep their defaults, which these periods never reach
    afp_field_pwm #(
        .PER_SHORT(22'h000064),
        .PER_LONG(22'h000190),
        .MIN_PW_LO(22'h00000A),
        .RETRY_PW_LO(22'h000003),
        .LAMP_DELAY(23'h000032)
    ) DUT (
        .clock(clock),
        .rst_b(rst_b),
        .flags(flags),
        .sense_code(sense_code),
        .bus(bus),
        .rdata(rdata),
        .drive(drive),
        .lamp(lamp),
        .irq(irq)
    );

    afp_field_model field (
        .drive(drive),
        .shorted(shorted),
        .field_hi(field_hi)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // one-cycle strobes; read data is taken in the cycle after the strobe
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1 v = rdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask
    // high time of the next whole drive pulse, bounded waits throughout
    task pulse();
        int n;
        n = 0;
        while (drive !== 1'b0 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        while (drive !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        t_b = t_a;
        t_a = $time;
        hi = 0;
        while (drive === 1'b1 && hi < 2000) begin
            @(negedge clock);
            hi++;
        end
        if (n >= 2000) hi = -1;
    endtask
    // drive must stay low for the whole span
    task watch(input int c);
        seen = 1'b0;
        repeat (c) begin
            @(negedge clock);
            seen = seen | drive;
        end
    endtask
    // sense is taken at the wrap, so the first pulse after a change is skipped
    task duty(input logic [7:0] c, input int e);
        @(posedge clock);
        sense_code <= c;
        pulse();
        pulse();
        `CHK(hi, e)
    endtask

    task close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        bus = '0;
        sense_code = 8'h40;
        {ign, sta, ov, shorted} = 4'h8;
        num_errors = 0;
        n_compared = 0;
        t_a = 0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        watch(150);
        `CHK(seen, 1'b0)
        `CHK(lamp, 1'b0)
        rchk(afp_pkg::OFS_PERIOD, 32'(afp_pkg::PER_TYP_CYC));
        wr(afp_pkg::OFS_PERIOD, PER);
        rchk(afp_pkg::OFS_PERIOD, PER);
        rchk(afp_pkg::OFS_SENSE_LO, 32'h60);
        rchk(afp_pkg::OFS_SENSE_HI, 32'hA0);
        rchk(afp_pkg::OFS_MIN_DUTY, 32'h7A);
        rchk(afp_pkg::OFS_RETRY_DUTY, 32'h14);
        rchk(afp_pkg::OFS_SLEW, 32'h1388);
        rchk(afp_pkg::OFS_IRQ_ENABLE, 32'h0);
        rchk(8'h28, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            duty(codes[i], exp_hi[i]);
        end
        `CHK((t_a - t_b) / 10, 200)
        wr(afp_pkg::OFS_PERIOD, 32'h32);
        rchk(afp_pkg::OFS_PERIOD, 32'h64);
        wr(afp_pkg::OFS_PERIOD, 32'h1000);
        rchk(afp_pkg::OFS_PERIOD, 32'h190);
        wr(afp_pkg::OFS_PERIOD, PER);
        duty(8'h40, 190);
        $display("test duty done");
        @(posedge clock);
        {ign, sta} <= 2'b00;
        watch(3);
        watch(400);
        `CHK(seen, 1'b0)
        sta <= 1'b1;
        duty(8'h40, 190);
        @(posedge clock);
        {ign, sta} <= 2'b10;
        repeat (45) @(negedge clock);
        `CHK(lamp, 1'b0)
        repeat (12) @(negedge clock);
        `CHK(lamp, 1'b1)
        sta <= 1'b1;
        repeat (5) @(negedge clock);
        `CHK(lamp, 1'b0)
        $display("test enable and lamp done");
        shorted <= 1'b1;
        duty(8'h40, 190);
        rchk(afp_pkg::OFS_IRQ_STATUS, 32'h4);
        wr(afp_pkg::OFS_SLEW, 32'h8);
        pulse();
        duty(8'h40, 4);
        rchk(afp_pkg::OFS_IRQ_STATUS, 32'h5);
        shorted <= 1'b0;
        pulse();
        duty(8'h40, 190);
        $display("test short done");
        ov <= 1'b1;
        repeat (2) @(negedge clock);
        watch(300);
        `CHK(seen, 1'b0)
        `CHK(lamp, 1'b1)
        rchk(afp_pkg::OFS_IRQ_STATUS, 32'h7);
        `CHK(irq, 1'b0)
        wr(afp_pkg::OFS_IRQ_ENABLE, 32'h2);
        repeat (2) @(negedge clock);
        `CHK(irq, 1'b1)
        wr(afp_pkg::OFS_IRQ_STATUS, 32'h0);
        rchk(afp_pkg::OFS_IRQ_STATUS, 32'h7);
        wr(afp_pkg::OFS_IRQ_CLEAR, 32'h7);
        rchk(afp_pkg::OFS_IRQ_STATUS, 32'h0);
        `CHK(irq, 1'b0)
        ov <= 1'b0;
        duty(8'h40, 190);
        $display("test overvoltage and irq done");
        close_out();
    end
endmodule

// ### inc/afp_pkg.sv
// shared constants, register map and carrier types of the field pwm block
package afp_pkg;
    // clock rate
    localparam int CLK_MHZ = 100;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    // oscillator rates in Hz; counts are whole clock cycles per period
    localparam int OSC_TYP_HZ = 175;
    localparam int OSC_MIN_HZ = 50;
    localparam int OSC_MAX_HZ = 500;
    localparam int PER_TYP_CYC = CLK_HZ / OSC_TYP_HZ;
    localparam int PER_LONG_CYC = CLK_HZ / OSC_MIN_HZ;
    localparam int PER_SHORT_CYC = CLK_HZ / OSC_MAX_HZ;
    // pulse width limits in microseconds and clock cycles
    localparam int MIN_PW_LO_US = 200;
    localparam int MIN_PW_HI_US = 700;
    localparam int RETRY_PW_LO_US = 60;
    localparam int RETRY_PW_HI_US = 660;
    localparam int MIN_PW_LO_CYC = MIN_PW_LO_US * CLK_MHZ;
    localparam int MIN_PW_HI_CYC = MIN_PW_HI_US * CLK_MHZ;
    localparam int RETRY_PW_LO_CYC = RETRY_PW_LO_US * CLK_MHZ;
    localparam int RETRY_PW_HI_CYC = RETRY_PW_HI_US * CLK_MHZ;
    // stator low time before the lamp lights, typical value
    localparam int LAMP_DELAY_US = 59400;
    localparam int LAMP_DELAY_CYC = LAMP_DELAY_US * CLK_MHZ;
    // duty figures in permille
    localparam logic [9:0] DUTY_TOP_PM = 10'h3B6;
    localparam logic [9:0] DUTY_BOT_PM = 10'h0C8;
    localparam logic [9:0] MIN_DUTY_LO_PM = 10'h028;
    localparam logic [9:0] MIN_DUTY_HI_PM = 10'h082;
    localparam logic [9:0] RETRY_LO_PM = 10'h00A;
    localparam logic [9:0] RETRY_HI_PM = 10'h032;
    localparam logic [31:0] PM_DIV = 32'h0000_03E8;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_PERIOD = 8'h00;
    localparam logic [7:0] OFS_SENSE_LO = 8'h04;
    localparam logic [7:0] OFS_SENSE_HI = 8'h08;
    localparam logic [7:0] OFS_MIN_DUTY = 8'h0C;
    localparam logic [7:0] OFS_RETRY_DUTY = 8'h10;
    localparam logic [7:0] OFS_SLEW = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] OFS_STATE = 8'h24;
    // reset values
    localparam logic [7:0] SENSE_LO_RST = 8'h60;
    localparam logic [7:0] SENSE_HI_RST = 8'hA0;
    localparam logic [9:0] MIN_DUTY_RST = 10'h07A;
    localparam logic [9:0] RETRY_DUTY_RST = 10'h014;
    localparam logic [15:0] SLEW_RST = 16'h1388;
    // interrupt status bit positions
    localparam int IRQ_SHORT = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_LAMP = 2;
    localparam int IRQ_W = 3;

    // digitized comparator outputs, already in the clock domain
    typedef struct packed {
        logic ign_on;
        logic stator_hi;
        logic supply_ov;
        logic field_hi;
    } afp_flags_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } afp_bus_t;
endpackage

// ### src/afp_field_pwm.sv
// alternator field pwm controller with short retry and lamp logic
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module afp_field_pwm #(
    parameter logic [21:0] PERIOD_RST = 22'(afp_pkg::PER_TYP_CYC),
    parameter logic [21:0] PER_SHORT = 22'(afp_pkg::PER_SHORT_CYC),
    parameter logic [21:0] PER_LONG = 22'(afp_pkg::PER_LONG_CYC),
    parameter logic [21:0] MIN_PW_LO = 22'(afp_pkg::MIN_PW_LO_CYC),
    parameter logic [21:0] MIN_PW_HI = 22'(afp_pkg::MIN_PW_HI_CYC),
    parameter logic [21:0] RETRY_PW_LO = 22'(afp_pkg::RETRY_PW_LO_CYC),
    parameter logic [21:0] RETRY_PW_HI = 22'(afp_pkg::RETRY_PW_HI_CYC),
    parameter logic [22:0] LAMP_DELAY = 23'(afp_pkg::LAMP_DELAY_CYC)
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire afp_pkg::afp_flags_t flags,
    input wire logic [7:0] sense_code,
    input wire afp_pkg::afp_bus_t bus,
    output logic [31:0] rdata,
    output logic drive,
    output logic lamp,
    output logic irq
);
    // period * permille / 1000
    function automatic logic [21:0] scale(input logic [21:0] p,
                                          input logic [9:0] pm);
        logic [31:0] prod;
        prod = 32'(p) * 32'(pm);
        return 22'(prod / afp_pkg::PM_DIV);
    endfunction

    function automatic logic [21:0] clamp(input logic [21:0] v,
                                          input logic [21:0] lo,
                                          input logic [21:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [9:0] clamp_pm(input logic [31:0] v,
                                            input logic [9:0] lo,
                                            input logic [9:0] hi);
        return (v < 32'(lo)) ? lo : ((v > 32'(hi)) ? hi : 10'(v));
    endfunction

    // sense code to duty; above the window the minimum duty takes over
    function automatic logic [9:0] duty_pm(input logic [7:0] code,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [19:0] num;
        logic [19:0] span;
        num = 20'(afp_pkg::DUTY_TOP_PM - afp_pkg::DUTY_BOT_PM)
              * 20'(code - lo);
        span = (hi > lo) ? 20'(hi - lo) : 20'h00001;
        if (code <= lo) begin
            return afp_pkg::DUTY_TOP_PM;
        end else if (code > hi) begin
            return 10'h000;
        end else begin
            return afp_pkg::DUTY_TOP_PM - 10'(num / span);
        end
    endfunction

    logic [21:0] period;
    logic [21:0] phase;
    logic [21:0] high_len;
    logic [7:0] sense_lo;
    logic [7:0] sense_hi;
    logic [7:0] sense_hold;
    logic [9:0] min_duty;
    logic [9:0] retry_duty;
    logic [15:0] slew;
    logic [15:0] coin;
    logic [22:0] stall;
    logic [2:0] irq_status;
    logic [2:0] irq_en;
    logic running;
    logic short_mode;
    logic short_seen;
    logic cut;
    logic ov_q;
    logic lamp_raw_q;

    // activity, ramp end and pulse window
    wire active = flags.ign_on | flags.stator_hi;
    wire wrap = (phase >= period - 22'h000001);
    wire in_pulse = (phase < high_len);
    wire drive_raw = running & active & ~flags.supply_ov & ~cut & in_pulse;
    wire coincide = drive & flags.field_hi;
    wire detect = ~short_mode & coincide & (coin >= slew);
    wire stopped = (stall >= LAMP_DELAY);
    wire lamp_raw = running & (flags.supply_ov | stopped);

    // next high time, chosen from the sense held over the past cycle
    wire [9:0] next_pm = duty_pm(sense_hold, sense_lo, sense_hi);
    wire [21:0] min_len = clamp(scale(period, min_duty), MIN_PW_LO,
                                MIN_PW_HI);
    wire [21:0] norm_raw = scale(period, next_pm);
    wire [21:0] norm_len = (norm_raw < min_len) ? min_len : norm_raw;
    wire [21:0] retry_len = clamp(scale(period, retry_duty), RETRY_PW_LO,
                                  RETRY_PW_HI);
    wire next_short = short_seen | detect | (short_mode & coincide);

    // register port decode
    wire wr_period = bus.wr & (bus.addr == afp_pkg::OFS_PERIOD);
    wire wr_lo = bus.wr & (bus.addr == afp_pkg::OFS_SENSE_LO);
    wire wr_hi = bus.wr & (bus.addr == afp_pkg::OFS_SENSE_HI);
    wire wr_min = bus.wr & (bus.addr == afp_pkg::OFS_MIN_DUTY);
    wire wr_retry = bus.wr & (bus.addr == afp_pkg::OFS_RETRY_DUTY);
    wire wr_slew = bus.wr & (bus.addr == afp_pkg::OFS_SLEW);
    wire wr_clear = bus.wr & (bus.addr == afp_pkg::OFS_IRQ_CLEAR);
    wire wr_en = bus.wr & (bus.addr == afp_pkg::OFS_IRQ_ENABLE);
    wire [21:0] wr_per_val = (bus.wdata > 32'(PER_LONG)) ? PER_LONG :
        clamp(bus.wdata[21:0], PER_SHORT, PER_LONG);

    // events: short declared, overvoltage onset, lamp onset
    wire [2:0] events = {lamp_raw & ~lamp_raw_q,
                         flags.supply_ov & ~ov_q, detect};
    wire [2:0] clr_mask = wr_clear ? bus.wdata[2:0] : 3'h0;

    wire [31:0] state_word = {25'h0, ov_q, stopped, cut, short_mode,
                              running, lamp, drive};
    logic [31:0] next_rdata;
    always_comb begin
        unique case (bus.addr)
            afp_pkg::OFS_PERIOD: next_rdata = 32'(period);
            afp_pkg::OFS_SENSE_LO: next_rdata = 32'(sense_lo);
            afp_pkg::OFS_SENSE_HI: next_rdata = 32'(sense_hi);
            afp_pkg::OFS_MIN_DUTY: next_rdata = 32'(min_duty);
            afp_pkg::OFS_RETRY_DUTY: next_rdata = 32'(retry_duty);
            afp_pkg::OFS_SLEW: next_rdata = 32'(slew);
            afp_pkg::OFS_IRQ_STATUS: next_rdata = 32'(irq_status);
            afp_pkg::OFS_IRQ_ENABLE: next_rdata = 32'(irq_en);
            afp_pkg::OFS_STATE: next_rdata = state_word;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // configuration registers; duty writes are clamped into spec bounds
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            period <= PERIOD_RST;
            sense_lo <= afp_pkg::SENSE_LO_RST;
            sense_hi <= afp_pkg::SENSE_HI_RST;
            min_duty <= afp_pkg::MIN_DUTY_RST;
            retry_duty <= afp_pkg::RETRY_DUTY_RST;
            slew <= afp_pkg::SLEW_RST;
            irq_en <= 3'h0;
        end else begin
            if (wr_period) period <= wr_per_val;
            if (wr_lo) sense_lo <= bus.wdata[7:0];
            if (wr_hi) sense_hi <= bus.wdata[7:0];
            if (wr_min) min_duty <= clamp_pm(bus.wdata,
                afp_pkg::MIN_DUTY_LO_PM, afp_pkg::MIN_DUTY_HI_PM);
            if (wr_retry) retry_duty <= clamp_pm(bus.wdata,
                afp_pkg::RETRY_LO_PM, afp_pkg::RETRY_HI_PM);
            if (wr_slew) slew <= bus.wdata[15:0];
            if (wr_en) irq_en <= bus.wdata[2:0];
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_status <= 3'h0;
            rdata <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~clr_mask) | events;
            rdata <= bus.rd ? next_rdata : 32'h0000_0000;
            irq <= |(irq_status & irq_en);
        end
    end

    // sense is sampled every clock; the value at ramp end is used
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sense_hold <= 8'h00;
        end else begin
            sense_hold <= sense_code;
        end
    end

    // oscillator ramp and cycle state
    always_ff @(posedge clock) begin
        if (!rst_b || !active) begin
            phase <= 22'h000000;
            running <= 1'b0;
            high_len <= 22'h000000;
            short_mode <= 1'b0;
            short_seen <= 1'b0;
            cut <= 1'b0;
        end else if (wrap) begin
            phase <= 22'h000000;
            running <= 1'b1;
            high_len <= next_short ? retry_len : norm_len;
            short_mode <= next_short;
            short_seen <= 1'b0;
            cut <= 1'b0;
        end else begin
            phase <= phase + 22'h000001;
            if (detect || (short_mode && coincide)) short_seen <= 1'b1;
            if (detect) cut <= 1'b1;
        end
    end

    // coincidence timer: must run unbroken past the slew time
    always_ff @(posedge clock) begin
        if (!rst_b || !coincide || wrap) begin
            coin <= 16'h0000;
        end else if (coin != 16'hFFFF) begin
            coin <= coin + 16'h0001;
        end
    end

    // stator low timer; stator high resets it at once
    always_ff @(posedge clock) begin
        if (!rst_b || !active || flags.stator_hi) begin
            stall <= 23'h000000;
        end else if (!stopped) begin
            stall <= stall + 23'h000001;
        end
    end

    // registered outputs; overvoltage kills drive and, once running, lights the lamp
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            drive <= 1'b0;
            lamp <= 1'b0;
            lamp_raw_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            drive <= drive_raw;
            lamp <= lamp_raw;
            lamp_raw_q <= lamp_raw;
            ov_q <= flags.supply_ov;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_drive_ov_off:
    assert property (flags.supply_ov |=> !drive)
        else $error("drive high after overvoltage");

    a_drive_idle_off:
    assert property (!active |=> !drive ##1 !drive)
        else $error("drive high while inactive");

    a_wrap_clears:
    assert property (active && wrap |=> phase == 22'h000000 && !cut)
        else $error("ramp end did not clear cycle");

    a_min_pulse_len:
    assert property (running && !short_mode |-> high_len >= MIN_PW_LO)
        else $error("normal pulse below minimum width");

    a_retry_pulse_len:
    assert property (running && short_mode |->
                     high_len >= RETRY_PW_LO && high_len <= RETRY_PW_HI)
        else $error("retry pulse width out of range");

    a_short_needs_slew:
    assert property ($rose(cut) |-> $past(coin) >= $past(slew))
        else $error("short declared before slew time");

    a_short_recovers:
    assert property (active && wrap && !next_short |=> !short_mode)
        else $error("short mode held without short");

    a_lamp_on_stall:
    assert property (running && active && stopped |=> lamp)
        else $error("lamp not lit after stator delay");

    a_first_cycle:
    assert property (!running |=> !drive && !lamp)
        else $error("output high before first cycle");
endmodule
